// >>> rtl/async_serial_transmitter.v
// Asynchronous serial transmitter with AXI4-Lite register access
`timescale 1ns/1ps
`include "serial_tx_regs.vh"
module async_serial_transmitter
(
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire [11:0] s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output reg         s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output reg         s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [11:0] s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output reg         s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   output wire        tx_o,
   output reg         tx_oe_o,
   output reg         core_irq_o,
   output reg         irq_o
);
   reg  [11:0] awaddr_ff;
   reg  [7:0]  wdata_ff;
   reg         wstrb0_ff;
   reg         aw_hold_ff;
   reg         w_hold_ff;
   reg         nxt_aw_hold;
   reg         nxt_w_hold;
   reg         nxt_bvalid;
   reg         nxt_rvalid;
   reg  [7:0]  int_ctrl_ff;
   reg  [7:0]  pflags_ff;
   reg  [7:0]  pen_ff;
   reg  [7:0]  rx_ctrl_ff;
   reg  [7:0]  tx_ctrl_ff;
   reg  [7:0]  baud_ff;
   reg  [7:0]  hold_data_ff;
   reg         hold_ninth_ff;
   reg         hold_full_ff;
   reg         buf_free_ff;
   reg  [1:0]  evt_stat_ff;
   reg  [1:0]  evt_mask_ff;
   reg  [7:0]  rd_val;
   reg         rd_ok;
   reg         wr_map;
   wire        aw_take;
   wire        w_take;
   wire        ar_take;
   wire        do_wr;
   wire        wr_ok;
   wire        wr_en;
   wire [7:0]  wr_idx;
   wire [7:0]  rd_idx;
   wire        tx_run;
   wire        buf_free;
   wire        load;
   wire        busy;
   wire        done;
   wire        bit_tick;
   wire [1:0]  evt_set;
   wire [1:0]  evt_clr;

   // Write channel: address and data taken in either order
   assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
   assign w_take  = s_axi_wvalid_i & s_axi_wready_o;
   assign do_wr   = aw_hold_ff & w_hold_ff & ~s_axi_bvalid_o;
   assign wr_idx  = awaddr_ff[9:2];
   assign wr_ok   = wr_map & (awaddr_ff[11:10] == 2'h0) & (awaddr_ff[1:0] == 2'h0);
   // Narrow registers live in byte lane 0 only
   assign wr_en   = do_wr & wr_ok & wstrb0_ff;
   assign ar_take = s_axi_arvalid_i & s_axi_arready_o;
   assign rd_idx  = s_axi_araddr_i[9:2];

   always @*
   begin
      nxt_aw_hold = aw_hold_ff;
      nxt_w_hold  = w_hold_ff;
      nxt_bvalid  = s_axi_bvalid_o;
      nxt_rvalid  = s_axi_rvalid_o;
      if (aw_take)
         nxt_aw_hold = 1'b1;
      if (w_take)
         nxt_w_hold = 1'b1;
      if (s_axi_bvalid_o && s_axi_bready_i)
         nxt_bvalid = 1'b0;
      if (do_wr)
      begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold  = 1'b0;
         nxt_bvalid  = 1'b1;
      end
      if (s_axi_rvalid_o && s_axi_rready_i)
         nxt_rvalid = 1'b0;
      if (ar_take)
         nxt_rvalid = 1'b1;
   end

   // Write address decode
   always @*
   begin
      if (wr_idx == `IDX_INT_CTRL)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_PERIPH_FLAGS)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_RX_CTRL)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_TX_HOLD)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_PERIPH_EN)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_TX_CTRL)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_BAUD_DIV)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_EVT_STATUS)
         wr_map = 1'b1;
      else if (wr_idx == `IDX_EVT_MASK)
         wr_map = 1'b1;
      else
         wr_map = 1'b0;
   end

   // Read mux; unimplemented and write-only bits read zero
   always @*
   begin
      rd_ok  = (s_axi_araddr_i[11:10] == 2'h0) & (s_axi_araddr_i[1:0] == 2'h0);
      rd_val = 8'h00;
      if (rd_idx == `IDX_INT_CTRL)
         rd_val = int_ctrl_ff;
      else if (rd_idx == `IDX_PERIPH_FLAGS)
         rd_val = {pflags_ff[7:6], 1'b0, buf_free, pflags_ff[3:0]};
      else if (rd_idx == `IDX_RX_CTRL)
         rd_val = {rx_ctrl_ff[7:3], 3'h0};
      else if (rd_idx == `IDX_TX_HOLD)
         rd_val = 8'h00;
      else if (rd_idx == `IDX_PERIPH_EN)
         rd_val = pen_ff;
      else if (rd_idx == `IDX_TX_CTRL)
         rd_val = {tx_ctrl_ff[7:4], 1'b0, tx_ctrl_ff[`TX_HS], ~busy, tx_ctrl_ff[0]};
      else if (rd_idx == `IDX_BAUD_DIV)
         rd_val = baud_ff;
      else if (rd_idx == `IDX_EVT_STATUS)
         rd_val = {6'h00, evt_stat_ff};
      else if (rd_idx == `IDX_EVT_MASK)
         rd_val = {6'h00, evt_mask_ff};
      else
         rd_ok = 1'b0;
   end

   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         awaddr_ff       <= 12'h000;
         wdata_ff        <= 8'h00;
         wstrb0_ff       <= 1'b0;
         aw_hold_ff      <= 1'b0;
         w_hold_ff       <= 1'b0;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `RESP_OKAY;
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rresp_o   <= `RESP_OKAY;
         s_axi_rdata_o   <= 32'h00000000;
      end
      else
      begin
         aw_hold_ff      <= nxt_aw_hold;
         w_hold_ff       <= nxt_w_hold;
         s_axi_bvalid_o  <= nxt_bvalid;
         s_axi_rvalid_o  <= nxt_rvalid;
         // Each ready only while its own channel holds nothing and no response is pending, so one write at a time
         s_axi_awready_o <= ~nxt_aw_hold & ~nxt_bvalid;
         s_axi_wready_o  <= ~nxt_w_hold & ~nxt_bvalid;
         s_axi_arready_o <= ~nxt_rvalid;
         if (aw_take)
            awaddr_ff <= s_axi_awaddr_i;
         if (w_take)
         begin
            wdata_ff  <= s_axi_wdata_i[7:0];
            wstrb0_ff <= s_axi_wstrb_i[0];
         end
         if (do_wr)
            s_axi_bresp_o <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         if (ar_take)
         begin
            // Refused reads return zero data
            s_axi_rdata_o <= {24'h000000, rd_ok ? rd_val : 8'h00};
            s_axi_rresp_o <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Transmit path control
   assign tx_run   = rx_ctrl_ff[`RX_PORT_ON] & ~tx_ctrl_ff[`TX_SYNC] & tx_ctrl_ff[`TX_ON];
   assign buf_free = tx_ctrl_ff[`TX_ON] & ~hold_full_ff;
   assign load     = tx_run & hold_full_ff & ~busy;
   assign evt_set  = {done, buf_free & ~buf_free_ff};
   assign evt_clr  = (wr_en && wr_idx == `IDX_EVT_STATUS) ? wdata_ff[1:0] : 2'h0;

   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         int_ctrl_ff   <= `RST_INT_CTRL;
         pflags_ff     <= `RST_PFLAGS;
         pen_ff        <= `RST_PEN;
         rx_ctrl_ff    <= `RST_RX_CTRL;
         tx_ctrl_ff    <= `RST_TX_CTRL;
         baud_ff       <= `RST_BAUD;
         hold_data_ff  <= `RST_HOLD;
         hold_ninth_ff <= 1'b0;
         hold_full_ff  <= 1'b0;
         buf_free_ff   <= 1'b0;
         evt_stat_ff   <= 2'h0;
         evt_mask_ff   <= 2'h0;
         tx_oe_o       <= 1'b0;
         core_irq_o    <= 1'b0;
         irq_o         <= 1'b0;
      end
      else
      begin
         if (wr_en && wr_idx == `IDX_INT_CTRL)
            int_ctrl_ff <= wdata_ff;
         if (wr_en && wr_idx == `IDX_PERIPH_FLAGS)
            pflags_ff <= {wdata_ff[7:6], 2'h0, wdata_ff[3:0]};
         if (wr_en && wr_idx == `IDX_PERIPH_EN)
            pen_ff <= wdata_ff;
         if (wr_en && wr_idx == `IDX_RX_CTRL)
            rx_ctrl_ff <= {wdata_ff[7:3], 3'h0};
         if (wr_en && wr_idx == `IDX_TX_CTRL)
            tx_ctrl_ff <= {wdata_ff[7:4], 1'b0, wdata_ff[`TX_HS], 1'b0, wdata_ff[`TX_NINTH]};
         if (wr_en && wr_idx == `IDX_BAUD_DIV)
            baud_ff <= wdata_ff;
         if (wr_en && wr_idx == `IDX_EVT_MASK)
            evt_mask_ff <= wdata_ff[1:0];
         // Ninth bit is captured with the byte, so load it first
         if (wr_en && wr_idx == `IDX_TX_HOLD)
         begin
            hold_data_ff  <= wdata_ff;
            hold_ninth_ff <= tx_ctrl_ff[`TX_NINTH];
            hold_full_ff  <= 1'b1;
         end
         else if (load)
            hold_full_ff <= 1'b0;
         buf_free_ff <= buf_free;
         // Set beats a same-cycle write-one clear
         evt_stat_ff <= (evt_stat_ff & ~evt_clr) | evt_set;
         irq_o       <= |(evt_stat_ff & evt_mask_ff);
         tx_oe_o     <= rx_ctrl_ff[`RX_PORT_ON];
         core_irq_o  <= int_ctrl_ff[`INT_GIE] & int_ctrl_ff[`INT_PERIPHERAL_IRQ_ENABLE] &
                        ((buf_free & pen_ff[`PE_TRANSMIT_IRQ_ENABLE]) |
                         (pflags_ff[7] & pen_ff[7]));
      end
   end

   baud_gen u_baud
   (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .clr_i   (~busy),
      .div_i   (baud_ff),
      .hs_i    (tx_ctrl_ff[`TX_HS]),
      .tick_o  (bit_tick)
   );

   tx_shifter u_shift
   (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .run_i      (tx_run),
      .tick_i     (bit_tick),
      .load_i     (load),
      .data_i     (hold_data_ff),
      .ninth_en_i (tx_ctrl_ff[`TX_NINE_EN]),
      .ninth_i    (hold_ninth_ff),
      .busy_o     (busy),
      .line_o     (tx_o),
      .done_o     (done)
   );
endmodule // async_serial_transmitter

// >>> rtl/serial_tx_regs.vh
// Register indices, field positions, reset values and counts of the serial transmitter
`ifndef SERIAL_TX_REGS_VH
`define SERIAL_TX_REGS_VH

// Register indices; byte address is four times the index
`define IDX_INT_CTRL     8'h0B
`define IDX_PERIPH_FLAGS 8'h0C
`define IDX_RX_CTRL      8'h18
`define IDX_TX_HOLD      8'h19
`define IDX_PERIPH_EN    8'h8C
`define IDX_TX_CTRL      8'h98
`define IDX_BAUD_DIV     8'h99
`define IDX_EVT_STATUS   8'hA0
`define IDX_EVT_MASK     8'hA1

// Transmit status/control fields
`define TX_CLKSRC  7
`define TX_NINE_EN 6
`define TX_ON      5
`define TX_SYNC    4
`define TX_HS      2
`define TX_EMPTY   1
`define TX_NINTH   0

// Other fields
`define RX_PORT_ON 7
`define INT_GIE    7
`define INT_PERIPHERAL_IRQ_ENABLE   6
`define PF_RECEIVE_FULL_FLAG    5
`define PF_TRANSMIT_BUFFER_FREE_FLAG    4
`define PE_RECEIVE_IRQ_ENABLE    5
`define PE_TRANSMIT_IRQ_ENABLE    4
`define EVT_FREE   0
`define EVT_DONE   1

// Reset values
`define RST_INT_CTRL 8'h00
`define RST_PFLAGS   8'h00
`define RST_PEN      8'h00
`define RST_RX_CTRL  8'h00
`define RST_TX_CTRL  8'h02
`define RST_BAUD     8'h00
`define RST_HOLD     8'h00

// Oversampling limits (16 and 64 minus one) and bits left after start
`define PRESC_HS     6'h0F
`define PRESC_LS     6'h3F
`define FRAME_LEFT_8 4'h9
`define FRAME_LEFT_9 4'hA

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> rtl/baud_gen.v
// Bit-rate tick generator from the baud divisor
`timescale 1ns/1ps
`include "serial_tx_regs.vh"
module baud_gen
(
   input  wire       mclk_i,
   input  wire       rst_n_i,
   input  wire       clr_i,
   input  wire [7:0] div_i,
   input  wire       hs_i,
   output reg        tick_o
);
   reg  [7:0] div_cnt_ff;
   reg  [5:0] pre_cnt_ff;
   wire [5:0] limit;

   assign limit = hs_i ? `PRESC_HS : `PRESC_LS;

   // Period is (div+1)*16 or (div+1)*64 clocks
   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_cnt_ff <= 8'h00;
         pre_cnt_ff <= 6'h00;
         tick_o     <= 1'b0;
      end
      else if (clr_i)
      begin
         // Idle cycle counts as the first, else the start bit runs one clock long
         div_cnt_ff <= (div_i == 8'h00) ? 8'h00 : 8'h01;
         pre_cnt_ff <= (div_i == 8'h00) ? 6'h01 : 6'h00;
         tick_o     <= 1'b0;
      end
      else if (div_cnt_ff == div_i)
      begin
         div_cnt_ff <= 8'h00;
         tick_o     <= (pre_cnt_ff == limit);
         pre_cnt_ff <= (pre_cnt_ff == limit) ? 6'h00 : pre_cnt_ff + 6'h01;
      end
      else
      begin
         div_cnt_ff <= div_cnt_ff + 8'h01;
         tick_o     <= 1'b0;
      end
   end
endmodule // baud_gen

// >>> rtl/tx_shifter.v
// Frame shifter: start bit, 8 or 9 data bits LSB first, stop bit
`timescale 1ns/1ps
`include "serial_tx_regs.vh"
module tx_shifter
(
   input  wire       mclk_i,
   input  wire       rst_n_i,
   input  wire       run_i,
   input  wire       tick_i,
   input  wire       load_i,
   input  wire [7:0] data_i,
   input  wire       ninth_en_i,
   input  wire       ninth_i,
   output reg        busy_o,
   output reg        line_o,
   output reg        done_o
);
   reg [9:0] shift_ff;
   reg [3:0] cnt_ff;

   always @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         shift_ff <= 10'h3FF;
         cnt_ff   <= 4'h0;
         busy_o   <= 1'b0;
         line_o   <= 1'b1;
         done_o   <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (!run_i)
         begin
            // Disabling aborts the frame and idles the line
            busy_o <= 1'b0;
            line_o <= 1'b1;
         end
         else if (load_i && !busy_o)
         begin
            shift_ff <= ninth_en_i ? {1'b1, ninth_i, data_i} : {2'b11, data_i};
            cnt_ff   <= ninth_en_i ? `FRAME_LEFT_9 : `FRAME_LEFT_8;
            busy_o   <= 1'b1;
            line_o   <= 1'b0;
         end
         else if (busy_o && tick_i)
         begin
            if (cnt_ff == 4'h0)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            else
            begin
               line_o   <= shift_ff[0];
               shift_ff <= {1'b1, shift_ff[9:1]};
               cnt_ff   <= cnt_ff - 4'h1;
            end
         end
      end
   end
endmodule // tx_shifter

// >>> dv/serial_tx_properties.sv
// Port-level checker for the serial transmitter
`timescale 1ns/1ps
module serial_tx_properties
(
   input wire        mclk_i,
   input wire        rst_n_i,
   input wire        s_axi_awvalid_i,
   input wire        s_axi_awready_o,
   input wire        s_axi_wvalid_i,
   input wire        s_axi_wready_o,
   input wire [1:0]  s_axi_bresp_o,
   input wire        s_axi_bvalid_o,
   input wire        s_axi_bready_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire        tx_o,
   input wire        tx_oe_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("bresp dropped early");
   a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("rdata dropped early");
   a_rdata_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
      else $error("rdata upper bits set");
   a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##2 s_axi_bvalid_o) else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_ready_held: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write ready during response");
   a_line_idle: assert property (!tx_oe_o && $past(!tx_oe_o) |-> tx_o)
      else $error("line low with port off");
   a_start_min: assert property ($fell(tx_o) |-> !tx_o [*8])
      else $error("bit too short");
   c_frame: cover property ($fell(tx_o));
   c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
   c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // serial_tx_properties

bind async_serial_transmitter serial_tx_properties i_chk
(
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .tx_o(tx_o), .tx_oe_o(tx_oe_o)
);

// >>> dv/serial_rx_model.sv
// Remote asynchronous receiver on the serial line
`timescale 1ns/1ps
module serial_rx_model
(
   input  wire        mclk_i,
   input  wire        line_i,
   input  wire [15:0] period_i,
   input  wire        nine_i,
   output logic [8:0] data_o,
   output int         count_o
);
   int i;
   initial
   begin
      count_o = 0;
      data_o = 9'h000;
      forever
      begin
         @(negedge line_i);
         // Mid-bit sampling tolerates edge jitter
         repeat (period_i / 2) @(posedge mclk_i);
         data_o = 9'h000;
         for (i = 0; i < (nine_i ? 9 : 8); i++)
         begin
            repeat (period_i) @(posedge mclk_i);
            data_o[i] = line_i;
         end
         repeat (period_i) @(posedge mclk_i);
         count_o++;
      end
   end
endmodule // serial_rx_model

// >>> dv/async_serial_transmitter_tb.sv
// Self-checking bench for the serial transmitter
`timescale 1ns/1ps
`include "serial_tx_regs.vh"
module async_serial_transmitter_tb;
   logic        mclk_i, rst_n_i, awv, wv, bry, arv, rry, tx_o, tx_oe_o, core_irq_o, irq_o;
   logic        awr, wr_o, bv, arr, rv, nine;
   logic [11:0] awa, ara;
   logic [31:0] wd, rd_o;
   logic [1:0]  br, rr;
   logic [15:0] period;
   logic [8:0]  rx_data;
   logic [31:0] d;
   logic [1:0]  r;
   int          rx_count, fail_count, tests_run, i;
   // Index and reset value per row
   logic [15:0] rows [8] = '{{`IDX_TX_CTRL, 8'h02}, {`IDX_PERIPH_FLAGS, 8'h00}, {`IDX_PERIPH_EN, 8'h00},
      {`IDX_BAUD_DIV, 8'h00}, {`IDX_INT_CTRL, 8'h00}, {`IDX_RX_CTRL, 8'h00}, {`IDX_EVT_STATUS, 8'h00},
      {`IDX_EVT_MASK, 8'h00}};

   async_serial_transmitter i_dut
   (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_o),
      .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
      .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd_o), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .tx_o(tx_o), .tx_oe_o(tx_oe_o), .core_irq_o(core_irq_o),
      .irq_o(irq_o)
   );
   serial_rx_model i_rx
   (
      .mclk_i(mclk_i), .line_i(tx_o), .period_i(period), .nine_i(nine), .data_o(rx_data), .count_o(rx_count)
   );

   function automatic [11:0] ad(input [7:0] idx);
      ad = {2'h0, idx, 2'h0};
   endfunction

   task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   task automatic wr(input [11:0] a, input [7:0] v, input [1:0] er);
      @(posedge mclk_i);
      awa <= a; wd <= {24'h000000, v}; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
      // No own limit; only the watchdog ends a hung wait
      do
      begin
         @(posedge mclk_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_o) wv <= 1'b0;
      end
      while (!bv);
      bry <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, br});
   endtask

   task automatic rd(input [11:0] a, output [31:0] v, output [1:0] e);
      @(posedge mclk_i);
      ara <= a; arv <= 1'b1; rry <= 1'b1;
      do
      begin
         @(posedge mclk_i);
         if (arv && arr) arv <= 1'b0;
      end
      while (!rv);
      rry <= 1'b0;
      v = rd_o;
      e = rr;
   endtask

   task automatic wait_rx(input int n, input [8:0] exp);
      while (rx_count < n) @(posedge mclk_i);
      chk("rx_data", {23'h0, exp}, {23'h0, rx_data});
   endtask

   task automatic complete_run;
      $display("Checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   initial
   begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      complete_run;
   end

   initial
   begin
      fail_count = 0; tests_run = 0; rst_n_i = 1'b0; awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0;
      rry = 1'b0; awa = 12'h000; ara = 12'h000; wd = 32'h0; period = 16'h0010; nine = 1'b0;
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         rd(ad(rows[i][15:8]), d, r);
         chk("reset value", {24'h0, rows[i][7:0]}, d);
      end
      rd(12'h004, d, r);
      chk("unmapped rresp", 32'h2, {30'h0, r});
      wr(12'h400, 8'hFF, `RESP_SLVERR);
      // Setup order as software must keep it
      wr(ad(`IDX_BAUD_DIV), 8'h00, `RESP_OKAY);
      wr(ad(`IDX_RX_CTRL), 8'h80, `RESP_OKAY);
      wr(ad(`IDX_PERIPH_EN), 8'h10, `RESP_OKAY);
      wr(ad(`IDX_INT_CTRL), 8'hC0, `RESP_OKAY);
      wr(ad(`IDX_EVT_MASK), 8'h01, `RESP_OKAY);
      repeat (2) @(posedge mclk_i);
      chk("core_irq off", 32'h0, {31'h0, core_irq_o});
      wr(ad(`IDX_TX_CTRL), 8'h24, `RESP_OKAY);
      rd(ad(`IDX_PERIPH_FLAGS), d, r);
      chk("buffer free", 32'h10, d);
      chk("irq set", 32'h1, {31'h0, irq_o});
      chk("core_irq on", 32'h1, {31'h0, core_irq_o});
      wr(ad(`IDX_PERIPH_EN), 8'h00, `RESP_OKAY);
      repeat (2) @(posedge mclk_i);
      chk("core_irq transmit_irq_enable off", 32'h0, {31'h0, core_irq_o});
      wr(ad(`IDX_PERIPH_EN), 8'h10, `RESP_OKAY);
      wr(ad(`IDX_INT_CTRL), 8'h80, `RESP_OKAY);
      repeat (2) @(posedge mclk_i);
      chk("core_irq gated", 32'h0, {31'h0, core_irq_o});
      wr(ad(`IDX_EVT_STATUS), 8'h01, `RESP_OKAY);
      repeat (2) @(posedge mclk_i);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      wr(ad(`IDX_EVT_MASK), 8'h00, `RESP_OKAY);
      wr(ad(`IDX_TX_HOLD), 8'hA5, `RESP_OKAY);
      rd(ad(`IDX_TX_CTRL), d, r);
      chk("shift busy", 32'h24, d);
      wait_rx(1, 9'h0A5);
      repeat (20) @(posedge mclk_i);
      rd(ad(`IDX_TX_CTRL), d, r);
      chk("shift empty", 32'h26, d);
      rd(ad(`IDX_EVT_STATUS), d, r);
      chk("events", 32'h03, d);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wr(ad(`IDX_TX_CTRL), 8'h65, `RESP_OKAY);
      nine = 1'b1;
      wr(ad(`IDX_TX_HOLD), 8'h3C, `RESP_OKAY);
      wait_rx(2, 9'h13C);
      repeat (20) @(posedge mclk_i);
      wr(ad(`IDX_BAUD_DIV), 8'h01, `RESP_OKAY);
      wr(ad(`IDX_TX_CTRL), 8'h20, `RESP_OKAY);
      period = 16'h0080;
      nine = 1'b0;
      wr(ad(`IDX_TX_HOLD), 8'h5A, `RESP_OKAY);
      wait_rx(3, 9'h05A);
      repeat (150) @(posedge mclk_i);
      // Clocked mode keeps the byte pending
      wr(ad(`IDX_TX_CTRL), 8'h30, `RESP_OKAY);
      wr(ad(`IDX_TX_HOLD), 8'h00, `RESP_OKAY);
      repeat (20) @(posedge mclk_i);
      rd(ad(`IDX_TX_CTRL), d, r);
      chk("clocked mode idle", 32'h32, d);
      chk("clocked mode line", 32'h1, {31'h0, tx_o});
      // Back to async sends the pending byte; abort it mid-frame by dropping the port
      wr(ad(`IDX_TX_CTRL), 8'h20, `RESP_OKAY);
      repeat (300) @(posedge mclk_i);
      chk("frame running", 32'h0, {31'h0, tx_o});
      wr(ad(`IDX_RX_CTRL), 8'h00, `RESP_OKAY);
      repeat (3) @(posedge mclk_i);
      chk("line abort", 32'h1, {31'h0, tx_o});
      chk("oe off", 32'h0, {31'h0, tx_oe_o});
      // Reset mid-run clears divisor and control
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd(ad(`IDX_BAUD_DIV), d, r);
      chk("baud after reset", 32'h0, d);
      rd(ad(`IDX_TX_CTRL), d, r);
      chk("tx_ctrl after reset", 32'h02, d);
      complete_run;
   end
endmodule // async_serial_transmitter_tb
